// >>> pkg/sms_pkg.sv
package sms_pkg;

	// Regulator outputs under test
	localparam int NUM_SW  = 3;
	localparam int NUM_LDO = 1;

	// Register map (byte-wide registers, word index)
	localparam logic [3:0] ADDR_CTRL    = 4'h0;
	localparam logic [3:0] ADDR_STATUS  = 4'h1;
	localparam logic [3:0] ADDR_IRQ     = 4'h2;
	localparam logic [3:0] ADDR_MASK    = 4'h3;
	localparam logic [3:0] ADDR_SW_OV   = 4'h4;
	localparam logic [3:0] ADDR_LDO_OV  = 4'h5;
	localparam logic [3:0] ADDR_SW_UV   = 4'h6;
	localparam logic [3:0] ADDR_LDO_UV  = 4'h7;
	localparam logic [3:0] ADDR_UNLOCK  = 4'h8;

	// CTRL bits
	localparam int CTRL_RUN_BIT  = 0;
	localparam int CTRL_PROT_BIT = 1;
	// STATUS and IRQ bits
	localparam int ST_BGF_BIT    = 0;
	localparam int ST_BUSY_BIT   = 1;
	localparam int ST_PGF_BIT    = 2;
	localparam int ST_FAIL_BIT   = 3;
	localparam int IRQ_BGF_BIT   = 0;

	localparam logic [7:0] UNLOCK_KEY = 8'hA5;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// Timing at 50 MHz
	localparam int CLK_MHZ         = 50;
	localparam int BLANK_US        = 200;
	localparam int BLANK_CYC       = BLANK_US * CLK_MHZ;
	localparam int PHASE_CYC       = 16;
	localparam int CNT_W           = 14;

	typedef enum logic [2:0] {
		SMS_IDLE  = 3'b000,
		SMS_FORCE = 3'b001,
		SMS_CHECK = 3'b011,
		SMS_PG    = 3'b010,
		SMS_DONE  = 3'b110
	} sms_state_t;

endpackage : sms_pkg

// >>> logic/sms_toggle_chk.sv
`timescale 1ns/1ps
// Watches one comparator: passes once it is seen both high and low
module sms_toggle_chk
	import sms_pkg::*;
(
	// Clocking
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic ce,
	// Control
	input  wire logic start,
	input  wire logic sample,
	input  wire logic comp_in,
	// Result
	output logic      failed
);
	logic seen_hi_r;
	logic seen_lo_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			seen_hi_r <= 1'b0;
			seen_lo_r <= 1'b0;
		end else if (ce) begin
			if (start) begin
				seen_hi_r <= 1'b0;
				seen_lo_r <= 1'b0;
			end else if (sample) begin
				seen_hi_r <= seen_hi_r | comp_in;
				seen_lo_r <= seen_lo_r | ~comp_in;
			end
		end
	end

	assign failed = ~(seen_hi_r & seen_lo_r);

endmodule : sms_toggle_chk

// >>> logic/sms_top.sv
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - Reference mismatch 5-12 % is critical fault
// - Mismatch at power-up fails test, stays down
// - Running drift, bypass 0: shut power stages
// - Running drift, bypass 1: interrupt only
// - Fault flag sticky, raised when unmasked
// - Live status follows reference comparison
// - Test every OV and UV comparator
// - Test also checks power-good output
// - Non-toggling comparator sets its warning bit
// - Four flag groups, one bit per output
// - Each run overwrites all result flags
// - Protected results need unlock to clear
// - Power-up continues after test despite comparator failures
// - Writing request bit starts a test
// - Request bit self-clears when test ends
// - Protected mode needs unlock to start
// - Fault blanking at most 200 us
// - On-demand failures set result flags
module sms_top
	import sms_pkg::*;
(
	// Clocking
	input  wire logic                         clk,
	input  wire logic                         resetn,
	input  wire logic                         ce,
	// Register port
	input  wire logic [3:0]                   reg_addr,
	input  wire logic [7:0]                   reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [7:0]                   reg_rdata,
	// Analog monitor interface
	input  wire logic                         ref_mismatch,
	input  wire logic                         bandgap_monitor_bypass,
	input  wire logic                         power_up_req,
	input  wire logic [sms_pkg::NUM_SW-1:0]   sw_ov_comp,
	input  wire logic [sms_pkg::NUM_SW-1:0]   sw_uv_comp,
	input  wire logic [sms_pkg::NUM_LDO-1:0]  ldo_ov_comp,
	input  wire logic [sms_pkg::NUM_LDO-1:0]  ldo_uv_comp,
	input  wire logic                         power_good_sense,
	// Control outputs
	output logic                              comp_test_force,
	output logic                              power_good_pin,
	output logic                              fault_blank,
	output logic                              power_stage_off,
	output logic                              power_up_ok,
	output logic                              irq_out
);
	import sms_pkg::*;

	localparam int NCMP = 2 * (NUM_SW + NUM_LDO);
	localparam logic [CNT_W-1:0] BLANK_MAX = CNT_W'(BLANK_CYC - 1);
	localparam logic [CNT_W-1:0] PHASE_MAX = CNT_W'(PHASE_CYC - 1);

	sms_state_t       state_r;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] blank_cnt_r;
	logic             run_r;
	logic             prot_r;
	logic             unlock_r;
	logic             irq_flag_r;
	logic             irq_mask_r;
	logic             stage_off_r;
	logic             pu_pending_r;
	logic             pu_test_r;
	logic             pu_done_r;
	logic             bg_fail_r;
	logic             pg_fail_r;
	logic             pg_seen_lo_r;
	logic [NUM_SW-1:0]  sw_ov_r;
	logic [NUM_SW-1:0]  sw_uv_r;
	logic [NUM_LDO-1:0] ldo_ov_r;
	logic [NUM_LDO-1:0] ldo_uv_r;
	logic [NCMP-1:0]    cmp_in;
	logic [NCMP-1:0]    cmp_fail;
	logic             test_start;
	logic             phase_end;
	logic             wr_ok;
	logic             run_req;
	logic [7:0]       ctrl_byte;
	logic [7:0]       status_byte;

	assign cmp_in = {ldo_uv_comp, sw_uv_comp, ldo_ov_comp, sw_ov_comp};

	// Each comparator gets its own toggle watcher
	for (genvar i = 0; i < NCMP; i++) begin : g_chk
		sms_toggle_chk u_chk (
			.clk     (clk),
			.resetn  (resetn),
			.ce      (ce),
			.start   (test_start),
			.sample  (state_r == SMS_FORCE || state_r == SMS_CHECK),
			.comp_in (cmp_in[i]),
			.failed  (cmp_fail[i])
		);
	end

	// Protected write: accepted only right after the unlock key
	assign wr_ok   = reg_wr && (!prot_r || unlock_r);
	assign run_req = wr_ok && reg_addr == ADDR_CTRL && reg_wdata[CTRL_RUN_BIT]
		&& !run_r && state_r == SMS_IDLE;
	assign test_start = (state_r == SMS_IDLE) && (run_req || (pu_pending_r && !pu_test_r));
	assign phase_end  = (cnt_r == PHASE_MAX);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			unlock_r <= 1'b0;
		end else if (ce) begin
			if (reg_wr)
				unlock_r <= (reg_addr == ADDR_UNLOCK) && (reg_wdata == UNLOCK_KEY);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prot_r     <= 1'b0;
			irq_mask_r <= 1'b1;
		end else if (ce) begin
			if (reg_wr && reg_addr == ADDR_CTRL)
				prot_r <= prot_r | reg_wdata[CTRL_PROT_BIT];
			if (reg_wr && reg_addr == ADDR_MASK)
				irq_mask_r <= reg_wdata[IRQ_BGF_BIT];
		end
	end

	// Test sequencer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= SMS_IDLE;
			cnt_r   <= '0;
		end else if (ce) begin
			case (state_r)
				SMS_IDLE: begin
					cnt_r <= '0;
					if (test_start)
						state_r <= SMS_FORCE;
				end
				SMS_FORCE: begin
					cnt_r <= phase_end ? '0 : cnt_r + 1'b1;
					if (phase_end)
						state_r <= SMS_CHECK;
				end
				SMS_CHECK: begin
					cnt_r <= phase_end ? '0 : cnt_r + 1'b1;
					if (phase_end)
						state_r <= SMS_PG;
				end
				SMS_PG: begin
					cnt_r <= phase_end ? '0 : cnt_r + 1'b1;
					if (phase_end)
						state_r <= SMS_DONE;
				end
				SMS_DONE: begin
					cnt_r   <= '0;
					state_r <= SMS_IDLE;
				end
				default: begin
					cnt_r   <= '0;
					state_r <= SMS_IDLE;
				end
			endcase
		end
	end

	// Stimulus toward the analog side; power-good is pulsed low then released
	assign comp_test_force = (state_r == SMS_FORCE);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			power_good_pin <= 1'b0;
			pg_seen_lo_r   <= 1'b0;
		end else if (ce) begin
			power_good_pin <= (state_r != SMS_PG) && pu_done_r && !stage_off_r;
			if (state_r == SMS_PG)
				pg_seen_lo_r <= pg_seen_lo_r | ~power_good_sense;
			else if (state_r == SMS_IDLE)
				pg_seen_lo_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			run_r <= 1'b0;
		end else if (ce) begin
			if (run_req)
				run_r <= 1'b1;
			else if (state_r == SMS_DONE)
				run_r <= 1'b0;
		end
	end

	// Results: overwritten at test end, cleared only by permitted writes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sw_ov_r   <= '0;
			ldo_ov_r  <= '0;
			sw_uv_r   <= '0;
			ldo_uv_r  <= '0;
			pg_fail_r <= 1'b0;
		end else if (ce) begin
			if (state_r == SMS_DONE) begin
				{ldo_uv_r, sw_uv_r, ldo_ov_r, sw_ov_r} <= cmp_fail;
				pg_fail_r <= ~pg_seen_lo_r;
			end else if (wr_ok) begin
				case (reg_addr)
					ADDR_SW_OV:  sw_ov_r  <= sw_ov_r & reg_wdata[NUM_SW-1:0];
					ADDR_LDO_OV: ldo_ov_r <= ldo_ov_r & reg_wdata[NUM_LDO-1:0];
					ADDR_SW_UV:  sw_uv_r  <= sw_uv_r & reg_wdata[NUM_SW-1:0];
					ADDR_LDO_UV: ldo_uv_r <= ldo_uv_r & reg_wdata[NUM_LDO-1:0];
					default:     pg_fail_r <= pg_fail_r;
				endcase
			end
		end
	end

	// Power-up handling
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pu_pending_r <= 1'b0;
			pu_test_r    <= 1'b0;
			pu_done_r    <= 1'b0;
			bg_fail_r    <= 1'b0;
		end else if (ce) begin
			if (power_up_req && !pu_pending_r && !pu_done_r && !bg_fail_r) begin
				pu_pending_r <= 1'b1;
				pu_test_r    <= 1'b0;
			end
			if (pu_pending_r && test_start)
				pu_test_r <= 1'b1;
			if (pu_pending_r && pu_test_r && ref_mismatch)
				bg_fail_r <= 1'b1;
			if (pu_pending_r && pu_test_r && state_r == SMS_DONE) begin
				pu_pending_r <= 1'b0;
				pu_done_r    <= !(bg_fail_r || ref_mismatch);
			end
		end
	end
	assign power_up_ok = pu_done_r && !stage_off_r;

	// Fault blanking window bounded by its own counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			blank_cnt_r <= '0;
			fault_blank <= 1'b0;
		end else if (ce) begin
			if (test_start && !(pu_pending_r && !pu_test_r)) begin
				fault_blank <= 1'b1;
				blank_cnt_r <= '0;
			end else if (fault_blank) begin
				blank_cnt_r <= blank_cnt_r + 1'b1;
				if (state_r == SMS_IDLE || blank_cnt_r == BLANK_MAX)
					fault_blank <= 1'b0;
			end
		end
	end

	// Running reference drift response
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stage_off_r <= 1'b0;
			irq_flag_r  <= 1'b0;
		end else if (ce) begin
			if (pu_done_r && ref_mismatch && !bandgap_monitor_bypass)
				stage_off_r <= 1'b1;
			if (ref_mismatch)
				irq_flag_r <= 1'b1;
			else if (reg_wr && reg_addr == ADDR_IRQ && reg_wdata[IRQ_BGF_BIT])
				irq_flag_r <= 1'b0;
		end
	end
	assign power_stage_off = stage_off_r || bg_fail_r;
	assign irq_out = irq_flag_r && !irq_mask_r;

	// Readback bytes built from the named positions, so the map is kept in one place
	always_comb begin
		ctrl_byte                = RESET_BYTE;
		ctrl_byte[CTRL_RUN_BIT]  = run_r;
		ctrl_byte[CTRL_PROT_BIT] = prot_r;
		status_byte              = RESET_BYTE;
		status_byte[ST_BGF_BIT]  = ref_mismatch;
		status_byte[ST_BUSY_BIT] = (state_r != SMS_IDLE);
		status_byte[ST_PGF_BIT]  = pg_fail_r;
		status_byte[ST_FAIL_BIT] = bg_fail_r;
	end

	// Read port
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= RESET_BYTE;
		end else if (ce) begin
			reg_rdata <= RESET_BYTE;
			if (reg_rd) begin
				case (reg_addr)
					ADDR_CTRL:   reg_rdata <= ctrl_byte;
					ADDR_STATUS: reg_rdata <= status_byte;
					ADDR_IRQ:    reg_rdata <= 8'(irq_flag_r);
					ADDR_MASK:   reg_rdata <= 8'(irq_mask_r);
					ADDR_SW_OV:  reg_rdata <= 8'(sw_ov_r);
					ADDR_LDO_OV: reg_rdata <= 8'(ldo_ov_r);
					ADDR_SW_UV:  reg_rdata <= 8'(sw_uv_r);
					ADDR_LDO_UV: reg_rdata <= 8'(ldo_uv_r);
					default:     reg_rdata <= RESET_BYTE;
				endcase
			end
		end
	end

	// Checks
	a_run_self_clear: assert property (@(posedge clk) disable iff (!resetn)
		ce && state_r == SMS_DONE |=> !run_r) else $error("request not cleared");
	a_blank_bounded: assert property (@(posedge clk) disable iff (!resetn)
		fault_blank |-> blank_cnt_r <= BLANK_MAX) else $error("blank too long");
	a_stage_shutdown: assert property (@(posedge clk) disable iff (!resetn)
		ce && pu_done_r && ref_mismatch && !bandgap_monitor_bypass |=> power_stage_off)
		else $error("no shutdown");
	a_bypass_irq: assert property (@(posedge clk) disable iff (!resetn)
		ce && ref_mismatch |=> irq_flag_r) else $error("flag not set");
	a_irq_masked: assert property (@(posedge clk) disable iff (!resetn)
		irq_mask_r |-> !irq_out) else $error("masked irq raised");
	a_busy_ignore: assert property (@(posedge clk) disable iff (!resetn)
		ce && state_r != SMS_IDLE && state_r != SMS_FORCE |=> state_r != SMS_FORCE)
		else $error("test restarted while busy");
	a_result_update: assert property (@(posedge clk) disable iff (!resetn)
		ce && state_r == SMS_DONE |=> sw_ov_r == $past(cmp_fail[NUM_SW-1:0]))
		else $error("results not stored");
	a_prot_reject: assert property (@(posedge clk) disable iff (!resetn)
		ce && reg_wr && prot_r && !unlock_r && state_r == SMS_IDLE |=> !run_r)
		else $error("unprotected start");
	a_pu_bg_down: assert property (@(posedge clk) disable iff (!resetn)
		bg_fail_r |-> !power_up_ok) else $error("powered despite mismatch");
	a_pg_pin_low: assert property (@(posedge clk) disable iff (!resetn)
		ce && state_r == SMS_PG |=> !power_good_pin)
		else $error("power good not pulsed");
	a_status_live: assert property (@(posedge clk) disable iff (!resetn)
		ce && reg_rd && reg_addr == ADDR_STATUS
		|=> reg_rdata[ST_BGF_BIT] == $past(ref_mismatch))
		else $error("status not live");
	a_blank_on_demand: assert property (@(posedge clk) disable iff (!resetn)
		ce && run_req && !pu_pending_r |=> fault_blank) else $error("no blanking");
	a_irq_sticky: assert property (@(posedge clk) disable iff (!resetn)
		ce && irq_flag_r && !(reg_wr && reg_addr == ADDR_IRQ && reg_wdata[IRQ_BGF_BIT])
		|=> irq_flag_r) else $error("flag lost");
	c_on_demand: cover property (@(posedge clk) run_req ##[1:60] state_r == SMS_DONE);
	c_power_up: cover property (@(posedge clk) $rose(pu_done_r));
	c_fail_flag: cover property (@(posedge clk) state_r == SMS_DONE && |cmp_fail);
	c_bypass_irq: cover property (@(posedge clk) irq_out && bandgap_monitor_bypass);
	c_pu_refused: cover property (@(posedge clk) $rose(bg_fail_r));

endmodule : sms_top

// >>> sim/sms_analog_model.sv
`timescale 1ns/1ps
// Comparators and power-good readback as seen from the control logic.
// A stuck bit holds its comparator low, so it never toggles under test.
module sms_analog_model
	import sms_pkg::*;
(
	// Clocking
	input  wire logic                  clk,
	// Fault injection
	input  wire logic                  slow,
	input  wire logic [NUM_SW-1:0]     stuck_sw_ov,
	input  wire logic [NUM_SW-1:0]     stuck_sw_uv,
	input  wire logic [NUM_LDO-1:0]    stuck_ldo_ov,
	input  wire logic [NUM_LDO-1:0]    stuck_ldo_uv,
	input  wire logic                  stuck_pg,
	// From the block
	input  wire logic                  comp_test_force,
	input  wire logic                  power_good_pin,
	// To the block
	output logic      [NUM_SW-1:0]     sw_ov_comp,
	output logic      [NUM_SW-1:0]     sw_uv_comp,
	output logic      [NUM_LDO-1:0]    ldo_ov_comp,
	output logic      [NUM_LDO-1:0]    ldo_uv_comp,
	output logic                       power_good_sense
);
	logic force_d_r;
	logic trip;

	// A slow comparator answers one cycle late
	always_ff @(posedge clk) begin
		force_d_r <= comp_test_force;
	end

	assign trip             = slow ? force_d_r : comp_test_force;
	assign sw_ov_comp       = {NUM_SW{trip}} & ~stuck_sw_ov;
	assign sw_uv_comp       = {NUM_SW{trip}} & ~stuck_sw_uv;
	assign ldo_ov_comp      = {NUM_LDO{trip}} & ~stuck_ldo_ov;
	assign ldo_uv_comp      = {NUM_LDO{trip}} & ~stuck_ldo_uv;
	// A shorted power-good line never reads low
	assign power_good_sense = power_good_pin | stuck_pg;
endmodule : sms_analog_model

// >>> sim/safety_monitor_selftest_bench.sv
`timescale 1ns/1ps
module safety_monitor_selftest_bench;
	import sms_pkg::*;
	logic clk = 0, resetn = 0, ce = 1, reg_wr = 0, reg_rd = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic ref_mismatch = 0, bandgap_monitor_bypass = 0, power_up_req = 0, slow = 0;
	logic [NUM_SW-1:0] sw_ov_comp, sw_uv_comp, stuck_sw_ov = '0, stuck_sw_uv = '0;
	logic [NUM_LDO-1:0] ldo_ov_comp, ldo_uv_comp, stuck_ldo_ov = '0, stuck_ldo_uv = '0;
	logic power_good_sense, stuck_pg = 0, comp_test_force, power_good_pin, fault_blank;
	logic power_stage_off, power_up_ok, irq_out;
	int   bad_count = 0, comparisons = 0, n;

	initial begin
		forever #10 clk = ~clk;
	end

	sms_top DUT (.clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ref_mismatch(ref_mismatch), .bandgap_monitor_bypass(bandgap_monitor_bypass),
		.power_up_req(power_up_req), .sw_ov_comp(sw_ov_comp), .sw_uv_comp(sw_uv_comp),
		.ldo_ov_comp(ldo_ov_comp), .ldo_uv_comp(ldo_uv_comp),
		.power_good_sense(power_good_sense), .comp_test_force(comp_test_force),
		.power_good_pin(power_good_pin), .fault_blank(fault_blank),
		.power_stage_off(power_stage_off), .power_up_ok(power_up_ok), .irq_out(irq_out));

	sms_analog_model MODEL (.clk(clk), .slow(slow), .stuck_sw_ov(stuck_sw_ov),
		.stuck_sw_uv(stuck_sw_uv), .stuck_ldo_ov(stuck_ldo_ov), .stuck_ldo_uv(stuck_ldo_uv),
		.stuck_pg(stuck_pg), .comp_test_force(comp_test_force),
		.power_good_pin(power_good_pin), .sw_ov_comp(sw_ov_comp), .sw_uv_comp(sw_uv_comp),
		.ldo_ov_comp(ldo_ov_comp), .ldo_uv_comp(ldo_uv_comp),
		.power_good_sense(power_good_sense));

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input string what, input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		chk(what, exp, reg_rdata);
	endtask : rd

	function automatic logic pick(input int k);
		case (k)
			0: return fault_blank;
			1: return power_up_ok;
			default: return power_stage_off;
		endcase
	endfunction : pick

	task automatic wait_lvl(input int k, input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while (pick(k) !== lvl) begin
			if (cnt == lim) begin
				bad_count++;
				$display("unexpected wait %0d: expected %b, seen %b", k, lvl, pick(k));
				give_verdict();
			end
			tick(1);
			cnt++;
		end
	endtask : wait_lvl

	task automatic check_results(input logic [7:0] e4, e5, e6, e7);
		rd("sw ov flags", ADDR_SW_OV, e4);
		rd("ldo ov flags", ADDR_LDO_OV, e5);
		rd("sw uv flags", ADDR_SW_UV, e6);
		rd("ldo uv flags", ADDR_LDO_UV, e7);
	endtask : check_results

	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		rd("ctrl reset", ADDR_CTRL, RESET_BYTE);
		rd("mask reset", ADDR_MASK, 8'h01);
		rd("unmapped", 4'h9, 8'h00);
		@(posedge clk);
		power_up_req <= 1'b1;
		wait_lvl(1, 1'b1, 200, n);
		chk("stage off", 8'h00, 8'(power_stage_off));
		check_results(8'h00, 8'h00, 8'h00, 8'h00);
		chk("power good pin", 8'h01, 8'(power_good_pin));
		// On-demand run with two dead comparators and slow analog
		stuck_sw_ov  <= 3'b010;
		stuck_ldo_uv <= 1'b1;
		slow         <= 1'b1;
		wr(ADDR_CTRL, 8'h01);
		wr(ADDR_CTRL, 8'h01);
		wait_lvl(0, 1'b1, 20, n);
		wait_lvl(0, 1'b0, BLANK_CYC + 10, n);
		chk("blank span", 8'h01, 8'(n <= 49 && n >= 40));
		rd("run cleared", ADDR_CTRL, 8'h00);
		check_results(8'h02, 8'h00, 8'h00, 8'h01);
		// Healthy comparators, shorted power-good: old flags must go
		stuck_sw_ov  <= '0;
		stuck_ldo_uv <= '0;
		slow         <= 1'b0;
		stuck_pg     <= 1'b1;
		wr(ADDR_CTRL, 8'h01);
		wait_lvl(0, 1'b1, 20, n);
		rd("status busy", ADDR_STATUS, 8'h02);
		wait_lvl(0, 1'b0, BLANK_CYC + 10, n);
		check_results(8'h00, 8'h00, 8'h00, 8'h00);
		rd("status pg fail", ADDR_STATUS, 8'h04);
		// Protected mode
		stuck_pg    <= 1'b0;
		stuck_sw_uv <= 3'b100;
		wr(ADDR_CTRL, 8'h02);
		wr(ADDR_CTRL, 8'h03);
		tick(3);
		chk("plain run refused", 8'h00, 8'(fault_blank));
		wr(ADDR_UNLOCK, UNLOCK_KEY);
		wr(ADDR_CTRL, 8'h03);
		wait_lvl(0, 1'b1, 20, n);
		wait_lvl(0, 1'b0, BLANK_CYC + 10, n);
		rd("sw uv after run", ADDR_SW_UV, 8'h04);
		wr(ADDR_SW_UV, 8'h00);
		rd("plain clear", ADDR_SW_UV, 8'h04);
		wr(ADDR_UNLOCK, UNLOCK_KEY);
		wr(ADDR_SW_UV, 8'h00);
		rd("unlocked clear", ADDR_SW_UV, 8'h00);
		// Clock enable low: a mask write must not land
		@(posedge clk);
		ce <= 1'b0;
		wr(ADDR_MASK, 8'h00);
		ce <= 1'b1;
		rd("mask frozen", ADDR_MASK, 8'h01);
		// Reference drift while on
		@(posedge clk);
		bandgap_monitor_bypass <= 1'b1;
		ref_mismatch           <= 1'b1;
		tick(3);
		chk("bypass keeps on", 8'h00, 8'(power_stage_off));
		chk("irq masked", 8'h00, 8'(irq_out));
		rd("irq flag", ADDR_IRQ, 8'h01);
		rd("status live", ADDR_STATUS, 8'h01);
		wr(ADDR_MASK, 8'h00);
		tick(1);
		chk("irq unmasked", 8'h01, 8'(irq_out));
		@(posedge clk);
		ref_mismatch <= 1'b0;
		wr(ADDR_IRQ, 8'h01);
		rd("irq cleared", ADDR_IRQ, 8'h00);
		rd("status back", ADDR_STATUS, 8'h00);
		@(posedge clk);
		bandgap_monitor_bypass <= 1'b0;
		ref_mismatch           <= 1'b1;
		wait_lvl(2, 1'b1, 8, n);
		// Mismatch during power-up
		@(posedge clk);
		resetn       <= 1'b0;
		power_up_req <= 1'b0;
		repeat (4) @(posedge clk);
		resetn                 <= 1'b1;
		bandgap_monitor_bypass <= 1'b1;
		power_up_req           <= 1'b1;
		tick(80);
		chk("no power up", 8'h00, 8'(power_up_ok));
		chk("stages held off", 8'h01, 8'(power_stage_off));
		rd("status test fail", ADDR_STATUS, 8'h09);
		give_verdict();
	end
endmodule : safety_monitor_selftest_bench
